// *** rtl/ppsf_pkg.sv ***
// Shared constants, states and carrier types for the push-pull soft-start sequencer.
package ppsf_pkg;

    // Oscillator cycles kept silent after a fault clears or after reset, plus the entry cycle.
    localparam int unsigned PPSF_HOLD_CYCLES = 58;
    // Sync-only cycles emitted before the first drive pulse.
    localparam int unsigned PPSF_SYNC_CYCLES = 2;
    // Number of soft-start steps before full width is allowed.
    localparam int unsigned PPSF_SS_STEPS = 7;
    // Width of the charge-phase length counter in reference clocks.
    localparam int unsigned PPSF_CNT_W = 12;
    // Width of the cycle counter used for the hold and sync phases.
    localparam int unsigned PPSF_CYC_W = 6;
    // Width of the soft-start step counter.
    localparam int unsigned PPSF_STEP_W = 3;
    // Shift that turns step times length into a fraction of the length (eighths).
    localparam int unsigned PPSF_FRAC_SH = 3;

    // Sequencer states.
    typedef enum logic [1:0] {
        PPSF_HOLD,
        PPSF_SYNC,
        PPSF_RAMP,
        PPSF_RUN
    } ppsf_state_type;

    // Output pins carried together so they are always registered on the same edge.
    typedef struct packed {
        logic drive_a;
        logic drive_b;
        logic sync;
    } ppsf_pins_type;

endpackage

// *** rtl/ppsf_seq.sv ***
// Push-pull toggle stage, sync output and fault/soft-start sequencer.
`timescale 1ns/1ps

module ppsf_seq
    import ppsf_pkg::*;
(
    input wire logic ref_clk, // Reference clock, 25 MHz.
    input wire logic rstn, // Undervoltage lockout, synchronous, active low.
    input wire logic osc_discharge, // High while the oscillator discharges its timing capacitor.
    input wire logic over_current, // High while the current-sense comparator trips.
    output logic drive_out_a, // Gate drive A, registered.
    output logic drive_out_b, // Gate drive B, registered.
    output logic sync_pulse_out // Sync to the secondary controller, registered.
);

    // Sequencer state and its next value.
    ppsf_state_type state_reg, state_next;
    // Oscillator cycle counter for the hold and sync phases.
    logic [PPSF_CYC_W-1:0] cyc_cnt_reg, cyc_cnt_next;
    // Soft-start step, 1 to 7 while ramping.
    logic [PPSF_STEP_W-1:0] ss_step_reg, ss_step_next;
    // Toggle selecting which output may pulse in the current cycle.
    logic side_reg;
    // Previous sample of the discharge input, for edge detection.
    logic dis_prev_reg;
    // Reference clocks elapsed in the present charge phase.
    logic [PPSF_CNT_W-1:0] chg_cnt_reg;
    // Length of the last complete charge phase.
    logic [PPSF_CNT_W-1:0] chg_len_reg;
    // Registered output pins and their next value.
    ppsf_pins_type pins_reg, pins_next;

    // A new oscillator cycle begins when the discharge interval starts.
    wire logic cycle_start = osc_discharge & ~dis_prev_reg;
    // Counter limits narrowed to the counter width.
    wire logic [PPSF_CYC_W-1:0] hold_last = PPSF_CYC_W'(PPSF_HOLD_CYCLES - 1);
    wire logic [PPSF_CYC_W-1:0] sync_last = PPSF_CYC_W'(PPSF_SYNC_CYCLES - 1);
    wire logic [PPSF_STEP_W-1:0] ss_last = PPSF_STEP_W'(PPSF_SS_STEPS);
    // Allowed pulse width during the ramp, in eighths of the last charge length.
    // Both factors are widened first, so the product keeps every bit.
    wire logic [PPSF_CNT_W+PPSF_STEP_W-1:0] ss_prod =
        (PPSF_CNT_W+PPSF_STEP_W)'(chg_len_reg) * (PPSF_CNT_W+PPSF_STEP_W)'(ss_step_reg);
    wire logic [PPSF_CNT_W-1:0] ss_width = PPSF_CNT_W'(ss_prod >> PPSF_FRAC_SH);
    // Leading edge is held back until only the allowed width remains.
    wire logic [PPSF_CNT_W-1:0] ss_blank = chg_len_reg - ss_width;
    wire logic width_ok = (state_next == PPSF_RUN) ||
                          ((state_next == PPSF_RAMP) && (chg_cnt_reg >= ss_blank));
    // Drives may switch only in ramp or run; sync runs in sync, ramp and run.
    wire logic sync_active = (state_next != PPSF_HOLD);
    wire logic drive_phase = ~osc_discharge & ~over_current & width_ok;
    // The toggle flips at every cycle start so each output sees half the rate.
    wire logic side_next = cycle_start ? ~side_reg : side_reg;

    // Sequencer: hold off, sync-only cycles, seven-step ramp, then full width.
    always_comb begin
        state_next = state_reg;
        cyc_cnt_next = cyc_cnt_reg;
        ss_step_next = ss_step_reg;
        if (over_current) begin
            // Any trip restarts the whole hold-off; counting resumes once it clears.
            state_next = PPSF_HOLD;
            cyc_cnt_next = '0;
        end else if (cycle_start) begin
            unique case (state_reg)
                PPSF_HOLD: begin
                    // Stay silent for the hold-off, then move to sync-only cycles.
                    if (cyc_cnt_reg == hold_last) begin
                        state_next = PPSF_SYNC;
                        cyc_cnt_next = '0;
                    end else begin
                        cyc_cnt_next = cyc_cnt_reg + 1'b1;
                    end
                end
                PPSF_SYNC: begin
                    // Sync pulses lead the first drive pulse by whole cycles.
                    if (cyc_cnt_reg == sync_last) begin
                        state_next = PPSF_RAMP;
                        ss_step_next = PPSF_STEP_W'(1);
                    end else begin
                        cyc_cnt_next = cyc_cnt_reg + 1'b1;
                    end
                end
                PPSF_RAMP: begin
                    // One step per oscillator cycle until the last step.
                    if (ss_step_reg == ss_last) begin
                        state_next = PPSF_RUN;
                    end else begin
                        ss_step_next = ss_step_reg + 1'b1;
                    end
                end
                PPSF_RUN: begin
                    // Full width until the next fault or lockout.
                    state_next = PPSF_RUN;
                end
            endcase
        end
    end

    // Output pins: sync tracks discharge, drives fill the charge phase of their turn.
    always_comb begin
        pins_next.sync = sync_active & osc_discharge;
        pins_next.drive_a = drive_phase & ~side_next;
        pins_next.drive_b = drive_phase & side_next;
    end

    // Sequencer and toggle registers.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg <= PPSF_HOLD;
            cyc_cnt_reg <= '0;
            ss_step_reg <= '0;
            side_reg <= 1'b0;
            // Tracks the pin through lockout, so release cannot fake a cycle start.
            dis_prev_reg <= osc_discharge;
        end else begin
            state_reg <= state_next;
            cyc_cnt_reg <= cyc_cnt_next;
            ss_step_reg <= ss_step_next;
            side_reg <= side_next;
            dis_prev_reg <= osc_discharge;
        end
    end

    // Charge-phase length measurement; saturates so a slow oscillator cannot wrap it.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            chg_cnt_reg <= '0;
            chg_len_reg <= '0;
        end else begin
            if (osc_discharge) begin
                chg_cnt_reg <= '0;
            end else if (chg_cnt_reg != '1) begin
                chg_cnt_reg <= chg_cnt_reg + 1'b1;
            end
            if (cycle_start) begin
                chg_len_reg <= chg_cnt_reg;
            end
        end
    end

    // Registered pins; all low during lockout.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pins_reg <= '0;
        end else begin
            pins_reg <= pins_next;
        end
    end

    assign drive_out_a = pins_reg.drive_a;
    assign drive_out_b = pins_reg.drive_b;
    assign sync_pulse_out = pins_reg.sync;

    // Checking helpers: which output pulsed last (1 = B) and whether any pulse was seen
    // since the last lockout or trip. A trip restarts the pairing, because the toggle keeps
    // running through the hold-off and the next pulse may then come from either side.
    logic last_b_reg;
    logic pulse_seen_reg;
    always_ff @(posedge ref_clk) begin
        if (!rstn || over_current) begin
            last_b_reg <= 1'b0;
            pulse_seen_reg <= 1'b0;
        end else if (drive_out_a) begin
            last_b_reg <= 1'b0;
            pulse_seen_reg <= 1'b1;
        end else if (drive_out_b) begin
            last_b_reg <= 1'b1;
            pulse_seen_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // A trip seen at one edge and gone at the next, and the quiet state it must leave:
    // both drives low and the sequencer back in its hold-off.
    sequence trip_s;
        over_current ##1 !over_current;
    endsequence
    sequence drive_off_s;
        !drive_out_a && !drive_out_b && (state_reg == PPSF_HOLD);
    endsequence

    sync_when_idle_a: assert property (sync_pulse_out |-> state_reg != PPSF_HOLD)
        else $error("Sync high while sequencer holds off.");
    sync_tracks_dis_a: assert property ((state_reg != PPSF_HOLD) && !over_current ##1
        (state_reg != PPSF_HOLD) && $past(osc_discharge) |-> sync_pulse_out)
        else $error("Sync does not follow the discharge interval.");
    sync_dead_time_a: assert property (sync_pulse_out |-> !drive_out_a && !drive_out_b)
        else $error("Drive high while sync is high.");
    drive_alternate_a: assert property ($rose(drive_out_a) && pulse_seen_reg |-> last_b_reg)
        else $error("Output A pulsed twice without B between.");
    drive_alt_b_a: assert property ($rose(drive_out_b) && pulse_seen_reg |-> !last_b_reg)
        else $error("Output B pulsed twice without A between.");
    trip_shutdown_a: assert property (trip_s |-> drive_off_s)
        else $error("Over-current did not shut the drives off.");
    hold_length_a: assert property ($rose(state_reg == PPSF_SYNC) |->
        $past(cyc_cnt_reg) == hold_last)
        else $error("Hold-off ended at the wrong count.");
    ramp_after_sync_a: assert property ($rose(state_reg == PPSF_RAMP) |->
        $past(state_reg) == PPSF_SYNC)
        else $error("Ramp began without sync-only cycles.");
    ramp_length_a: assert property ($rose(state_reg == PPSF_RUN) |->
        $past(ss_step_reg) == ss_last)
        else $error("Full width reached at the wrong step.");
    drive_needs_ramp_a: assert property ((drive_out_a || drive_out_b) |->
        (state_reg == PPSF_RAMP) || (state_reg == PPSF_RUN))
        else $error("Drive pulse before the soft-start ramp.");

endmodule

// *** bench/ppsf_osc_model.sv ***
// Behavioural timing oscillator that feeds the discharge interval to the sequencer.
`timescale 1ns/1ps

module ppsf_osc_model (
    input wire logic ref_clk, // Reference clock.
    input wire logic [7:0] charge_len, // Charge phase length in reference clocks.
    input wire logic [7:0] dis_len, // Discharge phase length in reference clocks.
    output logic osc_discharge // High while the timing capacitor discharges.
);
    int phase_cnt = 0; // Position inside the current oscillator cycle.

    initial osc_discharge = 1'b0;

    // It runs free through faults and lockout, which is the harder case for the sequencer.
    always @(posedge ref_clk) begin
        phase_cnt <= (phase_cnt + 1 >= charge_len + dis_len) ? 0 : phase_cnt + 1;
        osc_discharge <= (phase_cnt < dis_len);
    end
endmodule

// *** bench/test_ppsf_seq.sv ***
// Self-checking bench for the push-pull toggle, sync and soft-start sequencer.
`timescale 1ns/1ps

module test_ppsf_seq
    import ppsf_pkg::*;
;
    typedef struct {logic [7:0] chg; logic [7:0] dis; logic [7:0] exp_fw; logic [7:0] exp_sw;}
        ppsf_tb_row_type;
    ppsf_tb_row_type rows [3] = '{'{8'h08, 8'h02, 8'h08, 8'h02}, '{8'h0c, 8'h03, 8'h0c, 8'h03},
        '{8'h14, 8'h01, 8'h14, 8'h01}}; // Oscillator shape beside expected widths.
    logic ref_clk = 1'b0; // Starts low so time zero brings no false falling edge.
    logic rstn, over_current, osc_discharge, drive_out_a, drive_out_b, sync_pulse_out;
    logic [7:0] chg_len, dis_len, exp_fw, exp_sw; // Current oscillator shape and widths.
    logic osc_q, osc_q2, sync_q, drv_q, oc_q, oc_q2, rst_q, b_last; // Earlier samples.
    int errors = 0, checks_done = 0; // Verdict counters.
    int cyc, f_s, f_d, f_f, n_pre, n_a, n_b, w_d, w_s, last_w, rise_cyc; // Sequence tracking.

    ppsf_seq u_ppsf_seq (.ref_clk(ref_clk), .rstn(rstn), .osc_discharge(osc_discharge),
        .over_current(over_current), .drive_out_a(drive_out_a), .drive_out_b(drive_out_b),
        .sync_pulse_out(sync_pulse_out));
    ppsf_osc_model u_ppsf_osc_model (.ref_clk(ref_clk), .charge_len(chg_len), .dis_len(dis_len),
        .osc_discharge(osc_discharge));

    // Compares one value and reports any difference at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Judges one start-up sequence once it has reached full width.
    task automatic end_checks();
        check(16'(f_s >= 57), 16'h1);
        check(16'(f_d >= 57 && f_d <= 62), 16'h1);
        check(16'(f_d > f_s), 16'h1);
        // The count also holds the sync that opens the first drive cycle.
        check(16'(n_pre >= 2 && n_pre <= 3), 16'h1);
        check(16'(f_f - f_d >= 4 && f_f - f_d <= 7), 16'h1);
        check(16'(n_a - n_b <= 1 && n_b - n_a <= 1), 16'h1);
    endtask

    // Clock at 25 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Watch outputs at the falling edge, where every registered value has settled.
    always @(negedge ref_clk) begin
        check({14'h0, drive_out_a & drive_out_b, sync_pulse_out & (drive_out_a | drive_out_b)},
            16'h0);
        if (!rst_q || oc_q) check(16'(drive_out_a | drive_out_b), 16'h0);
        if (!rst_q || (oc_q && oc_q2)) check(16'(sync_pulse_out), 16'h0);
        if (rst_q && !oc_q && osc_q && !osc_q2) cyc++;
        if (sync_pulse_out === 1'b1) begin
            check(16'(osc_q), 16'h1);
            w_s++;
            if (!sync_q && f_s == 0) f_s = cyc;
            if (!sync_q && f_d == 0) n_pre++;
        end else if (sync_q === 1'b1) begin
            if (rst_q && !oc_q && !oc_q2) check(16'(w_s), 16'(exp_sw));
            w_s = 0;
        end
        if ((drive_out_a | drive_out_b) === 1'b1) begin
            if (!drv_q) begin
                if (f_d == 0) f_d = cyc;
                if (n_a + n_b > 0) check(16'(drive_out_b), 16'(!b_last));
                b_last = drive_out_b;
                rise_cyc = cyc;
                if (drive_out_b) n_b++;
                else n_a++;
            end
            w_d++;
        end else if (drv_q === 1'b1) begin
            // Widths must never shrink while the ramp opens the leading edge.
            if (rst_q && !oc_q) begin
                check(16'(w_d >= last_w), 16'h1);
                if (f_f != 0) check(16'(w_d), 16'(exp_fw));
                else if (w_d == exp_fw) f_f = rise_cyc;
            end
            last_w = w_d;
            w_d = 0;
        end
        // Lockout or a trip restarts the whole expected sequence.
        if (!rst_q || oc_q) begin
            {cyc, f_s, f_d, f_f, n_pre, n_a, n_b, w_d, w_s, last_w} = '0;
        end
        {osc_q2, osc_q, sync_q, drv_q} = {osc_q, osc_discharge, sync_pulse_out,
            drive_out_a | drive_out_b};
        {oc_q2, oc_q, rst_q} = {oc_q, over_current, rstn};
    end

    // Main sequence: one full start-up per row, then an over-current retry.
    initial begin
        {rstn, over_current, rst_q, oc_q, oc_q2, osc_q, osc_q2, sync_q, drv_q, b_last} = '0;
        {chg_len, dis_len, exp_fw, exp_sw} = {8'h08, 8'h02, 8'h08, 8'h02};
        foreach (rows[i]) begin
            @(posedge ref_clk);
            rstn <= 1'b0;
            {chg_len, dis_len, exp_fw, exp_sw} <= {rows[i].chg, rows[i].dis, rows[i].exp_fw,
                rows[i].exp_sw};
            repeat (3) @(posedge ref_clk);
            rstn <= 1'b1;
            repeat (80 * (rows[i].chg + rows[i].dis)) @(posedge ref_clk);
            end_checks();
            $display("test row %0d done", i);
        end
        // A trip in full run must stop both drives and replay the retry sequence.
        over_current <= 1'b1;
        repeat (4) @(posedge ref_clk);
        over_current <= 1'b0;
        repeat (80 * (chg_len + dis_len)) @(posedge ref_clk);
        end_checks();
        $display("test over-current retry done");
        print_verdict();
    end

    // Watchdog well beyond the roughly 215 us the tests need.
    initial begin
        #1000000;
        errors++;
        print_verdict();
    end
endmodule
